// ==== inc/tel_pkg.sv ====
// Constants and helpers for the threshold event latch config block
//
// Functional notes
// - Outside latch off: outside axis flags follow the condition live.
// - Outside latch on: outside axis flags stay set until source read.
// - Outside latch on: active flag only on false-to-true of condition.
// - Inside latch on: inside axis flags stay set until source read.
// - Inside latch off: inside axis flags follow the condition live.
// - Inside latch on: active flag only on false-to-true of condition.
// - X outside enable bit 5 includes or excludes X from outside test.
// - Bits 4,3 Y/Z outside; bits 2,1,0 X/Y/Z inside; all read/write.
// - Boot pin low: whole configuration register resets to zero.
// - Boot pin high: outside axis enables reset to one, rest zero.
// - Inside latch on: axis flags captured when inside condition rises.
// - Inside axis enable includes or excludes its axis from inside test.
package tel_pkg;

   // Configuration register layout
   localparam int unsigned CFG_W        = 8;
   localparam int unsigned AXIS_N       = 3;
   localparam int unsigned OUT_LATCH_B  = 7;
   localparam int unsigned IN_LATCH_B   = 6;
   localparam int unsigned OUT_AXIS_LSB = 3;
   localparam int unsigned IN_AXIS_LSB  = 0;

   // Reset value sets picked by the boot mode pin
   localparam logic [7:0] CFG_RST_GND = 8'h00;
   localparam logic [7:0] CFG_RST_VDD = 8'h38;

   // Register indices; byte address is four times the index
   localparam int unsigned IDX_W   = 6;
   localparam logic [5:0] IDX_SRC_OUT = 6'h2D;
   localparam logic [5:0] IDX_SRC_IN  = 6'h2E;
   localparam logic [5:0] IDX_CFG     = 6'h2F;
   localparam logic [5:0] IDX_STATUS  = 6'h3E;
   localparam logic [5:0] IDX_MASK    = 6'h3F;

   // Source register layout
   localparam int unsigned SRC_EA_B = 7;
   localparam int unsigned SRC_X_B  = 5;
   localparam int unsigned SRC_Y_B  = 3;
   localparam int unsigned SRC_Z_B  = 1;

   // Interrupt status layout
   localparam int unsigned INT_W     = 2;
   localparam int unsigned INT_OUT_B = 0;
   localparam int unsigned INT_IN_B  = 1;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Any enabled axis true: the outside condition
   function automatic logic tel_axis_any(input logic [2:0] cond,
                                         input logic [2:0] en);
      return |(cond & en);
   endfunction

   // Every enabled axis true, at least one enabled: the inside condition
   function automatic logic tel_axis_all(input logic [2:0] cond,
                                         input logic [2:0] en);
      return (&(cond | ~en)) & (|en);
   endfunction

   // Pack active flag and axis flags into a source register byte
   function automatic logic [7:0] tel_src_pack(input logic       ea,
                                               input logic [2:0] f);
      logic [7:0] v;
      v           = 8'h00;
      v[SRC_EA_B] = ea;
      v[SRC_X_B]  = f[2];
      v[SRC_Y_B]  = f[1];
      v[SRC_Z_B]  = f[0];
      return v;
   endfunction

endpackage

// ==== core/tel_sync2.sv ====
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module tel_sync2 import tel_pkg::*; (
   input  wire logic aclk,     // System clock
   input  wire logic async_in, // Asynchronous level
   output logic      sync_out  // Synchronised level
);

   typedef struct packed {
      logic meta;
      logic stable;
   } tel_sync_t;

   tel_sync_t s_q;
   tel_sync_t s_d;

   // No reset: the strap must flow through while reset is held
   always_comb begin
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign sync_out = s_q.stable;

endmodule // tel_sync2

// ==== core/tel_event_unit.sv ====
// Event flag unit: live or latched axis flags and active flag
`timescale 1ns/1ps
module tel_event_unit import tel_pkg::*; (
   input  wire logic       aclk,      // System clock
   input  wire logic       aresetn,   // Synchronous reset, active low
   input  wire logic [2:0] axis_cond, // Enabled per-axis condition
   input  wire logic       any_cond,  // Combined condition
   input  wire logic       latch_en,  // Latch mode select
   input  wire logic       src_clr,   // Source register read pulse
   output logic            active,    // Event active flag
   output logic [2:0]      flags,     // Per-axis event flags
   output logic            rise       // Condition false-to-true pulse
);

   typedef struct packed {
      logic       cond;
      logic       ea;
      logic [2:0] flags;
   } tel_evt_t;

   tel_evt_t s_q;
   tel_evt_t s_d;

   // Edge of the combined condition, armed only after it went false
   assign rise = any_cond & ~s_q.cond;

   always_comb begin
      s_d      = s_q;
      s_d.cond = any_cond;
      if (latch_en) begin
         if (src_clr) begin
            s_d.ea    = 1'b0;
            s_d.flags = 3'h0;
         end
         // Capture axis flags at the rise; set beats clear
         if (rise) begin
            s_d.ea    = 1'b1;
            s_d.flags = s_d.flags | axis_cond;
         end
      end else begin
         // Real-time flags, read has no effect
         s_d.ea    = any_cond;
         s_d.flags = axis_cond;
      end
      if (!aresetn) begin
         s_d = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign active = s_q.ea;
   assign flags  = s_q.flags;

endmodule // tel_event_unit

// ==== core/tel_threshold_event_config.sv ====
// Threshold event latch configuration block with AXI4-Lite register slave
`timescale 1ns/1ps
module tel_threshold_event_config import tel_pkg::*; #(
   parameter int unsigned ADDR_W = 8  // AXI address width
) (
   input  wire logic              aclk,            // System clock, 40 MHz
   input  wire logic              aresetn,         // Sync reset, active low
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address
   input  wire logic              s_axi_awvalid,   // Write address valid
   output logic                   s_axi_awready,   // Write address ready
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,     // Write data
   input  wire logic [3:0]        s_axi_wstrb,     // Write byte strobes
   input  wire logic              s_axi_wvalid,    // Write data valid
   output logic                   s_axi_wready,    // Write data ready
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,     // Write response
   output logic                   s_axi_bvalid,    // Write response valid
   input  wire logic              s_axi_bready,    // Write response ready
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address
   input  wire logic              s_axi_arvalid,   // Read address valid
   output logic                   s_axi_arready,   // Read address ready
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,     // Read data
   output logic [1:0]             s_axi_rresp,     // Read response
   output logic                   s_axi_rvalid,    // Read data valid
   input  wire logic              s_axi_rready,    // Read data ready
   // Strap and comparator side
   input  wire logic              boot_mode_pin,   // Boot mode strap
   input  wire logic [2:0]        axis_outside_cond, // X,Y,Z outside
   input  wire logic [2:0]        axis_inside_cond,  // X,Y,Z inside
   // Event outputs
   output logic                   outside_event_active,     // Outside EA
   output logic                   inside_event_active,      // Inside EA
   output logic [2:0]             axis_outside_event_flags, // X,Y,Z
   output logic [2:0]             axis_inside_event_flags,  // X,Y,Z
   output logic [7:0]             threshold_event_config,   // Config reg
   output logic                   irq                       // Interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // Types and state

   typedef enum logic [0:0] {
      WR_COLLECT = 1'b0,
      WR_RESP    = 1'b1
   } tel_wr_state_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } tel_rd_state_t;

   typedef struct packed {
      logic [7:0]       cfg;
      logic [INT_W-1:0] mask;
      logic [INT_W-1:0] status;
      tel_wr_state_t    wr_st;
      logic             aw_got;
      logic             w_got;
      logic [5:0]       wr_idx;
      logic [7:0]       wdata;
      logic             wstrb0;
      logic             bvalid;
      logic [1:0]       bresp;
      tel_rd_state_t    rd_st;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic             irq;
   } tel_state_t;

   tel_state_t s_q;
   tel_state_t s_d;

   ////////////////////////////////////////////////////////////////////////
   // Boot strap and condition evaluation

   logic       boot_sync;
   logic [2:0] out_en;
   logic [2:0] in_en;
   logic [2:0] out_axis;
   logic [2:0] in_axis;
   logic       out_any;
   logic       in_any;
   logic       out_clr;
   logic       in_clr;
   logic       out_rise;
   logic       in_rise;
   logic       out_ea;
   logic       in_ea;
   logic [2:0] out_flags;
   logic [2:0] in_flags;
   logic [5:0] rd_idx;
   logic       rd_hs;

   // Strap comes from a pin, so it is synchronised first
   tel_sync2 u_boot_sync (
      .aclk     (aclk),
      .async_in (boot_mode_pin),
      .sync_out (boot_sync)
   );

   // Per-axis outside enables from bits 5..3
   assign out_en = s_q.cfg[OUT_AXIS_LSB +: AXIS_N];
   // Per-axis inside enables from bits 2..0
   assign in_en  = s_q.cfg[IN_AXIS_LSB +: AXIS_N];

   // Disabled axes drop out of the outside test
   assign out_axis = axis_outside_cond & out_en;
   assign out_any  = tel_axis_any(axis_outside_cond, out_en);

   // Disabled axes drop out of the inside test
   assign in_axis = axis_inside_cond & in_en;
   assign in_any  = tel_axis_all(axis_inside_cond, in_en);

   ////////////////////////////////////////////////////////////////////////
   // Event flag units

   // Outside-of-thresholds flags and active flag
   tel_event_unit u_outside (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .axis_cond (out_axis),
      .any_cond  (out_any),
      .latch_en  (s_q.cfg[OUT_LATCH_B]),
      .src_clr   (out_clr),
      .active    (out_ea),
      .flags     (out_flags),
      .rise      (out_rise)
   );

   // Within-thresholds flags and active flag
   tel_event_unit u_inside (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .axis_cond (in_axis),
      .any_cond  (in_any),
      .latch_en  (s_q.cfg[IN_LATCH_B]),
      .src_clr   (in_clr),
      .active    (in_ea),
      .flags     (in_flags),
      .rise      (in_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus handshakes

   // Ready lines are combinational from registered state
   assign s_axi_awready = (s_q.wr_st == WR_COLLECT) & ~s_q.aw_got;
   assign s_axi_wready  = (s_q.wr_st == WR_COLLECT) & ~s_q.w_got;
   assign s_axi_arready = (s_q.rd_st == RD_IDLE);

   assign rd_hs  = s_axi_arvalid & s_axi_arready;
   assign rd_idx = s_axi_araddr[2 +: IDX_W];

   // A source read clears the latched flags
   assign out_clr = rd_hs & (rd_idx == IDX_SRC_OUT);
   assign in_clr  = rd_hs & (rd_idx == IDX_SRC_IN);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      s_d = s_q;

      // Write channel: address and data accepted in either order
      case (s_q.wr_st)
         WR_COLLECT: begin
            if (s_axi_awvalid && !s_q.aw_got) begin
               s_d.aw_got = 1'b1;
               s_d.wr_idx = s_axi_awaddr[2 +: IDX_W];
            end
            if (s_axi_wvalid && !s_q.w_got) begin
               s_d.w_got  = 1'b1;
               s_d.wdata  = s_axi_wdata[7:0];
               s_d.wstrb0 = s_axi_wstrb[0];
            end
            // Both halves held: commit one cycle later
            if (s_q.aw_got && s_q.w_got) begin
               s_d.bresp  = RESP_OKAY;
               s_d.bvalid = 1'b1;
               s_d.wr_st  = WR_RESP;
               if (s_q.wr_idx == IDX_CFG) begin
                  if (s_q.wstrb0) begin
                     s_d.cfg = s_q.wdata;
                  end
               end else if (s_q.wr_idx == IDX_MASK) begin
                  if (s_q.wstrb0) begin
                     s_d.mask = s_q.wdata[INT_W-1:0];
                  end
               end else if (s_q.wr_idx == IDX_SRC_OUT ||
                            s_q.wr_idx == IDX_SRC_IN ||
                            s_q.wr_idx == IDX_STATUS) begin
                  // Read-only: write ignored, answered okay
                  s_d.bresp = RESP_OKAY;
               end else begin
                  s_d.bresp = RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               s_d.bvalid = 1'b0;
               s_d.aw_got = 1'b0;
               s_d.w_got  = 1'b0;
               s_d.wr_st  = WR_COLLECT;
            end
         end
         default: begin
            s_d.wr_st = WR_COLLECT;
         end
      endcase

      // Read channel: data registered one cycle after the address
      case (s_q.rd_st)
         RD_IDLE: begin
            if (rd_hs) begin
               s_d.rd_st = RD_DATA;
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = RESP_OKAY;
               // Configuration reads back all eight bits
               if (rd_idx == IDX_CFG) begin
                  s_d.rdata[7:0] = s_q.cfg;
               end else if (rd_idx == IDX_SRC_OUT) begin
                  s_d.rdata[7:0] = tel_src_pack(out_ea, out_flags);
               end else if (rd_idx == IDX_SRC_IN) begin
                  s_d.rdata[7:0] = tel_src_pack(in_ea, in_flags);
               end else if (rd_idx == IDX_STATUS) begin
                  s_d.rdata[INT_W-1:0] = s_q.status;
               end else if (rd_idx == IDX_MASK) begin
                  s_d.rdata[INT_W-1:0] = s_q.mask;
               end else begin
                  s_d.rresp = RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            if (s_axi_rready) begin
               s_d.rd_st = RD_IDLE;
            end
         end
         default: begin
            s_d.rd_st = RD_IDLE;
         end
      endcase

      // Sticky status: read clears, a new event in that cycle wins
      if (rd_hs && rd_idx == IDX_STATUS) begin
         s_d.status = '0;
      end
      if (out_rise) begin
         s_d.status[INT_OUT_B] = 1'b1;
      end
      if (in_rise) begin
         s_d.status[INT_IN_B] = 1'b1;
      end

      // Level interrupt follows unmasked status, registered
      s_d.irq = |(s_d.status & s_d.mask);

      // Reset set chosen by the strap each reset cycle
      if (!aresetn) begin
         s_d = '0;
         s_d.cfg = boot_sync ? CFG_RST_VDD : CFG_RST_GND;
      end
   end

   // Single state register for the bus, config, status and irq state
   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Bus answers come straight from the state register
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp  = s_q.bresp;
   assign s_axi_rvalid = (s_q.rd_st == RD_DATA);
   assign s_axi_rdata  = s_q.rdata;
   assign s_axi_rresp  = s_q.rresp;

   // Event flags and configuration for the comparator side
   assign outside_event_active     = out_ea;
   assign inside_event_active      = in_ea;
   assign axis_outside_event_flags = out_flags;
   assign axis_inside_event_flags  = in_flags;
   assign threshold_event_config   = s_q.cfg;
   assign irq                      = s_q.irq;

endmodule // tel_threshold_event_config

// ==== test/tel_threshold_event_config_chk.sv ====
// Port-level assertions for the threshold event config block
`timescale 1ns/1ps
module tel_threshold_event_config_chk import tel_pkg::*; #(
   parameter int unsigned ADDR_W = 8 // Address width
) (
   input wire logic              aclk,                     // Clock
   input wire logic              aresetn,                  // Reset, low
   input wire logic              s_axi_awvalid,            // AW valid
   input wire logic              s_axi_awready,            // AW ready
   input wire logic              s_axi_wvalid,             // W valid
   input wire logic              s_axi_wready,             // W ready
   input wire logic              s_axi_bvalid,             // B valid
   input wire logic [ADDR_W-1:0] s_axi_araddr,             // AR address
   input wire logic              s_axi_arvalid,            // AR valid
   input wire logic              s_axi_arready,            // AR ready
   input wire logic              s_axi_rvalid,             // R valid
   input wire logic              boot_mode_pin,            // Strap
   input wire logic [2:0]        axis_outside_cond,        // Outside cond
   input wire logic [2:0]        axis_inside_cond,         // Inside cond
   input wire logic              outside_event_active,     // Outside active
   input wire logic              inside_event_active,      // Inside active
   input wire logic [2:0]        axis_outside_event_flags, // Outside flags
   input wire logic [2:0]        axis_inside_event_flags,  // Inside flags
   input wire logic [7:0]        threshold_event_config    // Config
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [2:0] en_o;
   logic [2:0] en_i;
   logic       lat_o;
   logic       lat_i;
   logic       any_o;
   logic       all_i;
   logic       rd_o;
   logic       rd_i;

   // Combined conditions, rebuilt here so a slip in the mux shows
   assign en_o  = threshold_event_config[5:3];
   assign en_i  = threshold_event_config[2:0];
   assign lat_o = threshold_event_config[7];
   assign lat_i = threshold_event_config[6];
   assign any_o = |(axis_outside_cond & en_o);
   assign all_i = (&(axis_inside_cond | ~en_i)) & (|en_i);
   assign rd_o  = s_axi_arvalid && s_axi_arready
                  && s_axi_araddr[7:2] == IDX_SRC_OUT;
   assign rd_i  = s_axi_arvalid && s_axi_arready
                  && s_axi_araddr[7:2] == IDX_SRC_IN;

   ////////////////////////////////////////////////////////////////////////
   // False-to-true steps of each condition in latch mode
   sequence s_out_rise;
      lat_o && !any_o ##1 lat_o && any_o;
   endsequence
   sequence s_in_rise;
      lat_i && !all_i ##1 lat_i && all_i;
   endsequence

   a_out_live_flags: assert property (
      !$past(lat_o) && $past(aresetn) |-> outside_event_active == $past(any_o)
      && axis_outside_event_flags == $past(axis_outside_cond & en_o))
      else $error("outside flags not live");
   a_in_live_flags: assert property (
      !$past(lat_i) && $past(aresetn) |-> inside_event_active == $past(all_i)
      && axis_inside_event_flags == $past(axis_inside_cond & en_i))
      else $error("inside flags not live");
   a_out_flag_hold: assert property (
      $past(lat_o) && !$past(rd_o) && $past(aresetn)
      |-> ($past(axis_outside_event_flags) & ~axis_outside_event_flags) == 0)
      else $error("latched outside flag dropped");
   a_in_flag_hold: assert property (
      $past(lat_i) && !$past(rd_i) && $past(aresetn)
      |-> ($past(axis_inside_event_flags) & ~axis_inside_event_flags) == 0)
      else $error("latched inside flag dropped");
   a_out_rise_only: assert property (
      $rose(outside_event_active) && $past(lat_o) && $past(aresetn, 2)
      |-> $past(any_o) && !$past(any_o, 2))
      else $error("outside active without a rise");
   a_in_rise_only: assert property (
      $rose(inside_event_active) && $past(lat_i) && $past(aresetn, 2)
      |-> $past(all_i) && !$past(all_i, 2))
      else $error("inside active without a rise");
   a_out_rise_sets: assert property (s_out_rise |=> outside_event_active)
      else $error("outside rise missed");
   a_in_capture: assert property (s_in_rise |=> inside_event_active &&
      (axis_inside_event_flags & $past(axis_inside_cond & en_i))
      == $past(axis_inside_cond & en_i))
      else $error("inside flags not captured");
   a_boot_reset: assert property ($rose(aresetn) |->
      threshold_event_config == (boot_mode_pin ? CFG_RST_VDD : CFG_RST_GND))
      else $error("config reset value wrong");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
endmodule // tel_threshold_event_config_chk

bind tel_threshold_event_config tel_threshold_event_config_chk #(
   .ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .boot_mode_pin,
   .axis_outside_cond, .axis_inside_cond, .outside_event_active,
   .inside_event_active, .axis_outside_event_flags,
   .axis_inside_event_flags, .threshold_event_config);

// ==== test/tel_threshold_event_config_test.sv ====
// Self-checking bench for the threshold event config block
`timescale 1ns/1ps
module tel_threshold_event_config_test import tel_pkg::*; ;
   localparam logic [7:0] A_CFG  = {IDX_CFG, 2'h0};
   localparam logic [7:0] A_SRCO = {IDX_SRC_OUT, 2'h0};
   localparam logic [7:0] A_SRCI = {IDX_SRC_IN, 2'h0};
   localparam logic [7:0] A_STAT = {IDX_STATUS, 2'h0};
   localparam logic [7:0] A_MASK = {IDX_MASK, 2'h0};

   logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
   logic        s_axi_arready, s_axi_rvalid, act_o, act_i;
   logic        aresetn = 1'h0, boot_mode_pin = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cfg;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, b_seen;
   logic [2:0]  cond_o = 3'h0, cond_i = 3'h0, flg_o, flg_i;
   int          err_total = 0, checked = 0, cyc = 0;

   tel_threshold_event_config #(.ADDR_W(8)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .boot_mode_pin,
      .axis_outside_cond(cond_o), .axis_inside_cond(cond_i),
      .outside_event_active(act_o), .inside_event_active(act_i),
      .axis_outside_event_flags(flg_o), .axis_inside_event_flags(flg_i),
      .threshold_event_config(cfg), .irq);

   ////////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz
   initial begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end

   // Hang guard, far above the some 170 cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Both write halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      // Response code taken at the edge that sees bvalid
      b_seen = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, e);
   endtask

   task automatic do_reset(input logic bm);
      @(posedge aclk);
      aresetn       <= 1'h0;
      boot_mode_pin <= bm;
      step(8);
      aresetn <= 1'h1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      rd_chk(A_CFG, 32'h0);
      do_reset(1'h1);
      rd_chk(A_CFG, 32'h38);
      do_reset(1'h0);
      check(cfg, 8'h00);
   endtask

   task automatic t_rw_bits();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 8; i++) begin
         wr(A_CFG, 32'h1 << i);
         check(b_seen, RESP_OKAY);
         rd_chk(A_CFG, 32'h1 << i);
         check(cfg, 8'h01 << i);
      end
      // Unmapped word: error answer, no alias onto the config
      rd(8'h00, d, r);
      check(r, RESP_SLVERR);
      check(d, 32'h0);
      wr(8'h00, 32'hFF);
      check(b_seen, RESP_SLVERR);
      rd_chk(A_CFG, 32'h80);
   endtask

   // Word is {out active, out flags, in active, in flags}
   task automatic t_live();
      wr(A_CFG, 32'h3F);
      cond_o <= 3'h5;
      cond_i <= 3'h7;
      step(2);
      check({act_o, flg_o, act_i, flg_i}, 8'hDF);
      cond_o <= 3'h0;
      cond_i <= 3'h3;
      step(2);
      check({act_o, flg_o, act_i, flg_i}, 8'h03);
      wr(A_CFG, 32'h1B);
      cond_o <= 3'h4;
      step(2);
      check({act_o, flg_o, act_i, flg_i}, 8'h0B);
      cond_o <= 3'h0;
      cond_i <= 3'h0;
   endtask

   // Word is {active, flags, irq}
   task automatic t_latch_out();
      wr(A_CFG, 32'hB8);
      rd_chk(A_STAT, 32'h3);
      wr(A_MASK, 32'h1);
      cond_o <= 3'h2;
      step(3);
      check({act_o, flg_o, irq}, 5'h15);
      cond_o <= 3'h0;
      step(3);
      check({act_o, flg_o, irq}, 5'h15);
      cond_o <= 3'h2;
      step(3);
      rd_chk(A_SRCO, 32'h88);
      check({act_o, flg_o}, 4'h0);
      rd_chk(A_STAT, 32'h1);
      check(irq, 1'h0);
      wr(A_MASK, 32'h0);
      cond_o <= 3'h0;
      step(2);
      cond_o <= 3'h4;
      step(3);
      check({act_o, flg_o, irq}, 5'h18);
      rd_chk(A_SRCO, 32'hA0);
      cond_o <= 3'h0;
   endtask

   task automatic t_latch_in();
      wr(A_CFG, 32'h47);
      cond_i <= 3'h7;
      step(3);
      check({act_i, flg_i}, 4'hF);
      cond_i <= 3'h3;
      step(3);
      check({act_i, flg_i}, 4'hF);
      rd_chk(A_SRCI, 32'hAA);
      check({act_i, flg_i}, 4'h0);
      cond_i <= 3'h7;
      step(3);
      check({act_i, flg_i}, 4'hF);
   endtask

   initial begin
      step(8);
      aresetn <= 1'h1;
      t_reset_vals();
      t_rw_bits();
      t_live();
      t_latch_out();
      t_latch_in();
      report_and_stop();
   end
endmodule // tel_threshold_event_config_test
